// File: rtl/tcfb_ctrl.sv
// tcfb_ctrl: per logical processor enable, class report and history reset enable registers.
// assumes synchronous event pulses and one-cycle strobes; read data valid one cycle after the read strobe.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [R1] enable register bit 0, rest reserved, resets zero
// [R2] enable writable whatever package config holds
// [R3] table keeps updating under package enable
// [R4] clearing enable discards class history
// [R5] class code readable while enable set
// [R6] secure launch clears package, pointer, enable
// [R7] authenticated entry clears socket package state
// [R8] soft restart clears this enable bit
// [R9] report: valid bit63, class code 7:0
// [R10] feedback only while enable bit set
// [R11] valid cleared when information is insufficient
// [R12] valid cleared when enable cleared
// [R13] valid cleared on enabled history reset
// [R14] history reset enable bit 0, rest reserved
// [R15] history reset instruction clears history when enabled
// [R16] management mode edge clears history under freeze
// [R17] secure launch clears history everywhere
// [R18] authenticated entry clears history here only
// [R19] soft restart clears history
// [R20] report valid only when support enumerated
// [R21] software ignores code while valid low
// [R22] software re-enables after restart or launch
// [R23] package bit0 table, bit1 class; bit0 dominates; here bit1 is unused and the class follows the thread enable only
// [R24] reserved bits read zero, writes ignored
module tcfb_ctrl
    import tcfb_pkg::*;
(
    input  wire logic        i_clk,          // core clock, 50 MHz
    input  wire logic        i_rstn,         // async reset, active low
    input  wire logic [15:0] i_addr,         // register word address
    input  wire logic [63:0] i_wdata,        // write data
    input  wire logic        i_wr,           // write strobe
    input  wire logic        i_rd,           // read strobe
    output logic      [63:0] o_rdata,        // read data, cycle after i_rd
    input  wire tcfb_evt_t   i_evt,          // implicit reset events
    input  wire tcfb_cls_t   i_cls,          // classifier sample
    input  wire logic        i_support,      // class report enumerated
    input  wire logic        i_dbg_ctl_frz,  // freeze-in-mgmt-mode of debug control
    input  wire logic [1:0]  i_pkg_cfg,      // package config bits 1:0
    output logic             o_pkg_clear,    // pulse: clear package config and pointer
    output logic             o_table_upd,    // shared table may update
    output logic             o_hist_clear,   // pulse: discard class history
    output logic             o_cls_en        // classifier running for this processor
);
    logic                    thread_en;      // enable register bit 0
    logic                    hrst_en;        // history reset enable bit 0
    logic                    valid;          // report valid flag
    logic [TCFB_CLASS_W-1:0] class_code;     // captured class code
    logic                    hist_clear;     // history discard this cycle
    logic                    en_wr_clr;      // software clearing the enable
    logic                    implicit_clr;   // hardware clearing the enable
    logic [63:0]             next_rdata;     // read mux

    // decode of enable writes
    assign en_wr_clr    = i_wr && (i_addr == TCFB_OFF_ENABLE) && !i_wdata[0] && thread_en;
    // secure launch reaches all sockets, entry only ours
    assign implicit_clr = i_evt.secure_launch | i_evt.auth_entry | i_evt.soft_restart;  // see [R6] see [R7] see [R8]

    // history discard: any documented cause
    always_comb
    begin
        hist_clear = en_wr_clr;                                         // see [R4]
        if (i_evt.hist_reset_insn && hrst_en)
            hist_clear = 1'b1;                                          // see [R15]
        if (i_evt.mgmt_enter_exit && i_dbg_ctl_frz)
            hist_clear = 1'b1;                                          // see [R16]
        if (i_evt.secure_launch || i_evt.auth_here || i_evt.soft_restart)
            hist_clear = 1'b1;                                          // see [R17] see [R18] see [R19]
    end

    // package enables are outside; hand them the clear
    assign o_pkg_clear  = i_evt.secure_launch | i_evt.auth_entry;       // see [R6] see [R7]
    // table updates follow package bit 0 only, not the thread enable
    assign o_table_upd  = i_pkg_cfg[0];                                 // see [R3] see [R23]
    assign o_hist_clear = hist_clear;
    assign o_cls_en     = thread_en;                                    // see [R10]

    // thread enable register; the implicit clear beats a set in the same cycle
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            thread_en <= TCFB_ENABLE_RST;                               // see [R1]
        else if (implicit_clr)
            thread_en <= 1'b0;
        else if (i_wr && i_addr == TCFB_OFF_ENABLE)
            thread_en <= i_wdata[0];                                    // see [R2] see [R24]
    end

    // history reset enable register
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            hrst_en <= TCFB_HRST_RST;
        else if (i_wr && i_addr == TCFB_OFF_HISTORY_RESET_INSTRUCTION)
            hrst_en <= i_wdata[0];                                      // see [R14] see [R24]
    end

    // class report: capture only while enabled and supported
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            valid      <= 1'b0;
            class_code <= '0;
        end
        else if (hist_clear || implicit_clr || !thread_en || !i_support)
            valid <= 1'b0;                                              // see [R12] see [R13] see [R20]
        else if (!i_cls.ready)
            valid <= 1'b0;                                              // see [R11]
        else
        begin
            valid      <= 1'b1;                                         // see [R5]
            class_code <= i_cls.code;                                   // see [R9]
        end
    end

    // read mux, reserved bits zero, unmapped reads zero
    always_comb
    begin
        next_rdata = TCFB_ZERO64;
        if (i_addr == TCFB_OFF_REPORT)
        begin
            next_rdata[TCFB_VALID_BIT]     = valid;                     // see [R9]
            next_rdata[TCFB_CLASS_W-1:0]   = class_code;
        end
        else if (i_addr == TCFB_OFF_ENABLE)
            next_rdata[0] = thread_en;
        else if (i_addr == TCFB_OFF_HISTORY_RESET_INSTRUCTION)
            next_rdata[0] = hrst_en;
    end

    // data stand one cycle after the read strobe, zero otherwise
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_rdata <= TCFB_ZERO64;
        else if (i_rd)
            o_rdata <= next_rdata;
        else
            o_rdata <= TCFB_ZERO64;
    end

    // valid never outlives a cleared enable by more than one cycle
    property p_valid_needs_en;
        @(posedge i_clk) disable iff (!i_rstn) valid |-> $past(thread_en);
    endproperty
    a_valid_needs_en: assert property (p_valid_needs_en) else $error("valid without enable"); // see [R10]

    property p_restart_clears;
        @(posedge i_clk) disable iff (!i_rstn) i_evt.soft_restart |=> !thread_en && !valid;
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("restart kept enable"); // see [R8]

    property p_launch_hist;
        @(posedge i_clk) disable iff (!i_rstn) i_evt.secure_launch |-> o_hist_clear && o_pkg_clear;
    endproperty
    a_launch_hist: assert property (p_launch_hist) else $error("launch missed clear"); // see [R17]

    property p_hrst_gate;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_evt.hist_reset_insn && hrst_en) |=> !valid;
    endproperty
    a_hrst_gate: assert property (p_hrst_gate) else $error("history reset kept valid"); // see [R13]

    property p_sw_clear;
        @(posedge i_clk) disable iff (!i_rstn) en_wr_clr |-> o_hist_clear ##1 !valid;
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("enable clear kept history"); // see [R4]

    property p_support;
        @(posedge i_clk) disable iff (!i_rstn) !i_support |=> !valid;
    endproperty
    a_support: assert property (p_support) else $error("valid without support"); // see [R20]

    property p_notready;
        @(posedge i_clk) disable iff (!i_rstn) !i_cls.ready |=> !valid;
    endproperty
    a_notready: assert property (p_notready) else $error("valid without information"); // see [R11]

    property p_rd_en;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_rd && i_addr == TCFB_OFF_ENABLE) |=> o_rdata == {63'h0, $past(thread_en)};
    endproperty
    a_rd_en: assert property (p_rd_en) else $error("enable readback wrong"); // see [R24]

    property p_table;
        @(posedge i_clk) disable iff (!i_rstn) !i_pkg_cfg[0] |-> !o_table_upd;
    endproperty
    a_table: assert property (p_table) else $error("table updating while off"); // see [R23]

    // the shared table keeps updating under package bit 0 with the thread enable clear
    // the per-processor enable must never gate the package-level table
    property p_table_on;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_pkg_cfg[0] && !thread_en) |-> o_table_upd;
    endproperty
    a_table_on: assert property (p_table_on) else $error("table stopped without thread enable"); // see [R3]

    // a plain software write lands when no implicit clear competes
    // package configuration bits play no part in this path
    property p_en_write;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_wr && i_addr == TCFB_OFF_ENABLE && !implicit_clr) |=> thread_en == $past(i_wdata[0]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost"); // see [R2]

    // enable only moves on a write or an implicit clear
    // reserved write data or other addresses must leave it alone
    property p_en_hold;
        @(posedge i_clk) disable iff (!i_rstn)
            (!(i_wr && i_addr == TCFB_OFF_ENABLE) && !implicit_clr) |=> $stable(thread_en);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable moved without cause"); // see [R24]

    // secure launch drops the enable bit on every processor
    // software has to set it again afterwards
    property p_launch_en;
        @(posedge i_clk) disable iff (!i_rstn)
            i_evt.secure_launch |=> !thread_en && !valid;
    endproperty
    a_launch_en: assert property (p_launch_en) else $error("launch kept enable"); // see [R6]

    // authenticated entry on this socket drops the enable bit
    // the package clear is raised in the same cycle
    property p_auth_en;
        @(posedge i_clk) disable iff (!i_rstn)
            i_evt.auth_entry |=> !thread_en;
    endproperty
    a_auth_en: assert property (p_auth_en) else $error("entry kept enable"); // see [R7]

    // package clear pulse accompanies socket-local authenticated entry
    // the package registers live outside this block
    property p_auth_pkg;
        @(posedge i_clk) disable iff (!i_rstn)
            i_evt.auth_entry |-> o_pkg_clear;
    endproperty
    a_auth_pkg: assert property (p_auth_pkg) else $error("entry missed package clear"); // see [R7]

    // no package clear without one of its two causes
    // a stray pulse would wipe the table pointer
    property p_pkg_quiet;
        @(posedge i_clk) disable iff (!i_rstn)
            (!i_evt.secure_launch && !i_evt.auth_entry) |-> !o_pkg_clear;
    endproperty
    a_pkg_quiet: assert property (p_pkg_quiet) else $error("package clear without cause"); // see [R6]

    // history discard only on the executing processor for entry
    // other processors of the socket keep their history
    property p_auth_hist;
        @(posedge i_clk) disable iff (!i_rstn)
            i_evt.auth_here |-> o_hist_clear;
    endproperty
    a_auth_hist: assert property (p_auth_hist) else $error("entry kept history"); // see [R18]

    // restart or startup wait always discards history
    // whatever brought the processor there
    property p_restart_hist;
        @(posedge i_clk) disable iff (!i_rstn)
            i_evt.soft_restart |-> o_hist_clear;
    endproperty
    a_restart_hist: assert property (p_restart_hist) else $error("restart kept history"); // see [R19]

    // management mode edges discard history only under freeze
    // without freeze the event alone must not clear
    property p_mgmt_hist;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_evt.mgmt_enter_exit && i_dbg_ctl_frz) |-> o_hist_clear;
    endproperty
    a_mgmt_hist: assert property (p_mgmt_hist) else $error("management edge kept history"); // see [R16]

    // enabled history reset instruction discards history
    // the gate bit is the history reset enable register
    property p_hrst_hist;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_evt.hist_reset_insn && hrst_en) |-> o_hist_clear;
    endproperty
    a_hrst_hist: assert property (p_hrst_hist) else $error("history reset ignored"); // see [R15]

    // nothing else may discard history
    // a gated instruction or unfrozen mode edge stays silent
    property p_hist_quiet;
        @(posedge i_clk) disable iff (!i_rstn)
            (!en_wr_clr && !(i_evt.hist_reset_insn && hrst_en) && !(i_evt.mgmt_enter_exit && i_dbg_ctl_frz)
             && !i_evt.secure_launch && !i_evt.auth_here && !i_evt.soft_restart) |-> !o_hist_clear;
    endproperty
    a_hist_quiet: assert property (p_hist_quiet) else $error("history cleared without cause"); // see [R15]

    // a software clear of the enable drops valid next cycle
    property p_sw_clear_valid;
        @(posedge i_clk) disable iff (!i_rstn)
            en_wr_clr |=> !valid;
    endproperty
    a_sw_clear_valid: assert property (p_sw_clear_valid) else $error("enable clear kept valid"); // see [R12]

    // valid implies the enable is still set right now
    // every path that clears the enable also clears valid
    property p_valid_en_now;
        @(posedge i_clk) disable iff (!i_rstn)
            valid |-> thread_en;
    endproperty
    a_valid_en_now: assert property (p_valid_en_now) else $error("valid with enable clear"); // see [R10]

    // valid only follows a cycle with support enumerated
    property p_valid_support;
        @(posedge i_clk) disable iff (!i_rstn)
            valid |-> $past(i_support);
    endproperty
    a_valid_support: assert property (p_valid_support) else $error("valid after no support"); // see [R20]

    // valid only follows a cycle with enough information
    property p_valid_ready;
        @(posedge i_clk) disable iff (!i_rstn)
            valid |-> $past(i_cls.ready);
    endproperty
    a_valid_ready: assert property (p_valid_ready) else $error("valid after classifier not ready"); // see [R11]

    // with every condition met the code is captured and flagged
    // the code comes straight from the classifier sample
    property p_capture;
        @(posedge i_clk) disable iff (!i_rstn)
            (thread_en && i_support && i_cls.ready && !hist_clear && !implicit_clr)
            |=> valid && class_code == $past(i_cls.code);
    endproperty
    a_capture: assert property (p_capture) else $error("class code not captured"); // see [R5]

    // code only changes while valid is being set
    // software keeps the last known class while valid is low
    property p_code_hold;
        @(posedge i_clk) disable iff (!i_rstn)
            $changed(class_code) |-> valid;
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("class code moved while invalid"); // see [R21]

    // report readback: valid at the top, reserved middle zero
    property p_rd_report;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_rd && i_addr == TCFB_OFF_REPORT)
            |=> o_rdata[TCFB_VALID_BIT] == $past(valid) && o_rdata[TCFB_VALID_BIT-1:TCFB_CLASS_W] == '0;
    endproperty
    a_rd_report: assert property (p_rd_report) else $error("report readback wrong"); // see [R9]

    // history reset enable readback, reserved bits zero
    property p_rd_hrst;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_rd && i_addr == TCFB_OFF_HISTORY_RESET_INSTRUCTION) |=> o_rdata == {63'h0, $past(hrst_en)};
    endproperty
    a_rd_hrst: assert property (p_rd_hrst) else $error("history reset enable readback wrong"); // see [R14]

    // unmapped reads and idle cycles leave the data bus at zero
    // keeps a stale word from being taken as a fresh answer
    property p_rd_zero;
        @(posedge i_clk) disable iff (!i_rstn)
            (!i_rd || (i_addr != TCFB_OFF_REPORT && i_addr != TCFB_OFF_ENABLE && i_addr != TCFB_OFF_HISTORY_RESET_INSTRUCTION))
            |=> o_rdata == TCFB_ZERO64;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data not zero"); // see [R24]

    // history reset enable takes bit 0 of a write
    property p_hrst_write;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_wr && i_addr == TCFB_OFF_HISTORY_RESET_INSTRUCTION) |=> hrst_en == $past(i_wdata[0]);
    endproperty
    a_hrst_write: assert property (p_hrst_write) else $error("history reset enable write lost"); // see [R14]

    // history reset enable holds without a write to it
    property p_hrst_hold;
        @(posedge i_clk) disable iff (!i_rstn)
            !(i_wr && i_addr == TCFB_OFF_HISTORY_RESET_INSTRUCTION) |=> $stable(hrst_en);
    endproperty
    a_hrst_hold: assert property (p_hrst_hold) else $error("history reset enable moved"); // see [R24]

    c_valid: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(valid));
    c_hrst:  cover property (@(posedge i_clk) disable iff (!i_rstn) i_evt.hist_reset_insn && hrst_en && valid);
    c_launch: cover property (@(posedge i_clk) disable iff (!i_rstn) i_evt.secure_launch && thread_en);
    c_swclr: cover property (@(posedge i_clk) disable iff (!i_rstn) en_wr_clr && valid);
endmodule
`default_nettype wire

// File: rtl/tcfb_pkg.sv
// tcfb_pkg: constants and carrier types for the thread class feedback control block.
// assumes a single core clock domain and a plain one-cycle register port.
package tcfb_pkg;
    // register offsets (printed word addresses, one 64-bit register each)
    localparam logic [15:0] TCFB_OFF_REPORT  = 16'h17d2;
    localparam logic [15:0] TCFB_OFF_ENABLE  = 16'h17d4;
    localparam logic [15:0] TCFB_OFF_HISTORY_RESET_INSTRUCTION  = 16'h17d8;   // placed after the other two, with 16'h17d6 left unmapped
    // field positions
    localparam int TCFB_VALID_BIT  = 63;
    localparam int TCFB_CLASS_W    = 8;
    localparam int TCFB_DBG_FRZ    = 14;
    // reset values
    localparam logic       TCFB_ENABLE_RST = 1'b0;
    localparam logic       TCFB_HRST_RST   = 1'b0;
    localparam logic [1:0] TCFB_PKG_RST    = 2'b00;
    localparam logic [63:0] TCFB_ZERO64    = 64'h0000_0000_0000_0000;

    // implicit reset events from the core
    typedef struct packed {
        logic secure_launch;    // system-wide launch, seen on every socket
        logic auth_entry;       // authenticated code entry on this socket
        logic auth_here;        // entry executed by this logical processor
        logic soft_restart;     // restart signal or wait-for-startup state
        logic mgmt_enter_exit;  // entry or exit of management mode
        logic hist_reset_insn;  // history reset instruction retired here
    } tcfb_evt_t;

    // classifier sample from the core
    typedef struct packed {
        logic                    ready;   // classifier has enough information
        logic [TCFB_CLASS_W-1:0] code;    // current workload class code
    } tcfb_cls_t;
endpackage

// File: dv/thread_class_feedback_ctrl_bench.sv
// thread_class_feedback_ctrl_bench: self-checking bench for the per-processor class feedback registers.
// assumes tcfb_pkg and tcfb_ctrl are compiled first; 50 MHz core clock, read data one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module thread_class_feedback_ctrl_bench
    import tcfb_pkg::*;
();
    // one ordinary case: enable write, classifier, package bits, expected report
    typedef struct packed {
        logic [63:0] en;
        logic        rdy;
        logic [7:0]  code;
        logic        sup;
        logic [1:0]  pkg;
        logic [63:0] rep;
    } tcfb_row_t;
    logic        i_clk, i_rstn, i_wr, i_rd, i_support, i_dbg_ctl_frz; // driven inputs
    logic [15:0] i_addr;                                              // register address
    logic [63:0] i_wdata, o_rdata, rd_val;                            // bus data, last read
    logic [1:0]  i_pkg_cfg;                                           // package config bits
    tcfb_evt_t   i_evt;                                               // event pulses
    tcfb_cls_t   i_cls;                                               // classifier sample
    logic        o_pkg_clear, o_table_upd, o_hist_clear, o_cls_en;    // design flags
    int          errors, total_checks;                                // verdict counters
    // code 8'hff is the top boundary of the class field
    tcfb_row_t   rows [5] = '{
        '{64'hffff_ffff_ffff_ffff, 1'b1, 8'ha5, 1'b1, 2'b01, 64'h8000_0000_0000_00a5},
        '{64'h0000_0000_0000_0001, 1'b0, 8'h00, 1'b1, 2'b10, 64'h0000_0000_0000_0000},
        '{64'h0000_0000_0000_0000, 1'b1, 8'h5a, 1'b1, 2'b11, 64'h0000_0000_0000_0000},
        '{64'h0000_0000_0000_0001, 1'b1, 8'h3c, 1'b0, 2'b00, 64'h0000_0000_0000_0000},
        '{64'h0000_0000_0000_0001, 1'b1, 8'hff, 1'b1, 2'b00, 64'h8000_0000_0000_00ff}};
    tcfb_ctrl tcfb_ctrl_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_evt(i_evt), .i_cls(i_cls), .i_support(i_support),
        .i_dbg_ctl_frz(i_dbg_ctl_frz), .i_pkg_cfg(i_pkg_cfg), .o_pkg_clear(o_pkg_clear),
        .o_table_upd(o_table_upd), .o_hist_clear(o_hist_clear), .o_cls_en(o_cls_en));
    // free-running core clock
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    task automatic report_and_stop;
        if (errors == 0 && total_checks > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // register word compare
    task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // flag pair compare
    task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: flags %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [15:0] a, input logic [63:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [15:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rd_val = o_rdata;
    endtask
    // one-cycle event pulse, comb flags looked at inside the pulse
    task automatic ev(input tcfb_evt_t e, input logic [1:0] exp);
        @(posedge i_clk);
        i_evt <= e;
        #1 chk2({o_pkg_clear, o_hist_clear}, exp);
        @(posedge i_clk);
        i_evt <= '0;
    endtask
    // hang guard
    initial
    begin
        #1_000_000;
        errors++;
        report_and_stop();
    end
    initial
    begin
        {i_rstn, i_wr, i_rd, i_support, i_dbg_ctl_frz, i_addr, i_wdata, i_pkg_cfg} = '0;
        i_evt = '0;
        i_cls = '0;
        errors = 0;
        total_checks = 0;
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(TCFB_OFF_ENABLE);  chk64(rd_val, TCFB_ZERO64);
        rd(TCFB_OFF_HISTORY_RESET_INSTRUCTION);  chk64(rd_val, TCFB_ZERO64);
        rd(TCFB_OFF_REPORT);  chk64(rd_val, TCFB_ZERO64);
        // ordinary cases: invalid reports only compare valid flag and reserved bits
        foreach (rows[k])
        begin
            @(posedge i_clk);
            i_cls <= '{ready: rows[k].rdy, code: rows[k].code};
            i_support <= rows[k].sup;
            i_pkg_cfg <= rows[k].pkg;
            wr(TCFB_OFF_ENABLE, rows[k].en);
            rd(TCFB_OFF_ENABLE);  chk64(rd_val, {63'h0, rows[k].en[0]});
            rd(TCFB_OFF_REPORT);
            chk64(rd_val & (rows[k].rep[63] ? 64'hffff_ffff_ffff_ffff : 64'hffff_ffff_ffff_ff00),
                  rows[k].rep);
            chk2({o_table_upd, o_cls_en}, {rows[k].pkg[0], rows[k].en[0]});
        end
        wr(TCFB_OFF_HISTORY_RESET_INSTRUCTION, 64'hffff_ffff_ffff_ffff);
        rd(TCFB_OFF_HISTORY_RESET_INSTRUCTION);  chk64(rd_val, 64'h0000_0000_0000_0001);
        wr(16'h17d6, 64'hffff_ffff_ffff_ffff);
        rd(16'h17d6);         chk64(rd_val, TCFB_ZERO64);
        ev(6'h01, 2'b01);
        wr(TCFB_OFF_HISTORY_RESET_INSTRUCTION, TCFB_ZERO64);
        ev(6'h01, 2'b00);
        i_dbg_ctl_frz <= 1'b1;
        ev(6'h02, 2'b01);
        i_dbg_ctl_frz <= 1'b0;
        ev(6'h02, 2'b00);
        ev(6'h20, 2'b11);
        rd(TCFB_OFF_ENABLE);  chk64(rd_val, TCFB_ZERO64);
        wr(TCFB_OFF_ENABLE, 64'h0000_0000_0000_0001);
        ev(6'h18, 2'b11);
        rd(TCFB_OFF_ENABLE);  chk64(rd_val, TCFB_ZERO64);
        ev(6'h08, 2'b01);
        wr(TCFB_OFF_ENABLE, 64'h0000_0000_0000_0001);
        ev(6'h04, 2'b01);
        rd(TCFB_OFF_ENABLE);  chk64(rd_val, TCFB_ZERO64);
        // second reset in mid-run
        wr(TCFB_OFF_ENABLE, 64'h0000_0000_0000_0001);
        i_rstn <= 1'b0;
        @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(TCFB_OFF_ENABLE);  chk64(rd_val, TCFB_ZERO64);
        report_and_stop();
    end
endmodule
`default_nettype wire
